// ---- src/hs_pwm_gen_config.sv ----
// Summary of operation
// - one frequency bit per generator, 0 gives 100 Hz, 1 gives 200 Hz.
// - duty value is ten bits held in configuration bits 13 to 4.
// - output is on for duty/1024 of each period for duty values below all ones.
// - duty all zeros holds switch off, all ones holds it on.
// - bank field 000 to 011 selects generator; codes 1xx are ignored.
// - configuration bits 15 and 3 always read zero.
// - generators are internal, driving only the high-side switch modulation.
// - period and duty timing come from the internal clock.
// - sixteen-bit read-write scratch store used only by the host.
// - power-up and soft reset clear the scratch store to zero.
// - scratch store is reachable only in normal operating mode.
// - logic never alters scratch store; it survives fail-safe and restart.
`timescale 1ns/1ns
`default_nettype none
`include "hs_pwm_defs.svh"

module hs_pwm_gen_config #(
  parameter int SLOT_SLOW = `SLOT_CYC_SLOW,
  parameter int SLOT_FAST = `SLOT_CYC_FAST
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_soft_rst,
  input wire logic i_restart,
  input wire logic i_normal_mode,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire hs_pwm_pkg::reg_sel_t i_reg_sel,
  input wire hs_pwm_pkg::word_t i_wdata,
  output hs_pwm_pkg::word_t o_rdata,
  output logic o_rd_valid,
  output logic o_access_blocked,
  output logic [`NUM_GEN-1:0] o_internal_modulator_n
);
  import hs_pwm_pkg::*;

  gen_cfg_if gen_bus ();

  logic clr_all;
  logic modulator_sel;
  logic scratch_sel;
  logic scratch_ok;
  logic wr_modulator;
  logic wr_scratch;
  logic bank_valid;
  logic wr_bank_valid;
  bank_t wr_bank;
  logic [1:0] wr_idx;
  logic [1:0] rd_idx;
  logic [`NUM_GEN-1:0] wr_hit;

  bank_t bank_ff;
  logic freq_ff [`NUM_GEN];
  duty_t duty_ff [`NUM_GEN];
  word_t scratch_ff;
  word_t rdata_ff;
  logic rd_valid_ff;
  logic blocked_ff;
  logic [`NUM_GEN-1:0] mod_out;
  word_t cfg_word;
  word_t nxt_rdata;

  // =====================================================================
  // access decode
  assign clr_all = i_srst || i_soft_rst;
  assign modulator_sel = (i_reg_sel == SEL_MODULATOR);
  assign scratch_sel = (i_reg_sel == SEL_SCRATCH);
  assign scratch_ok = i_normal_mode;
  assign wr_modulator = i_wr_en && modulator_sel;
  assign wr_scratch = i_wr_en && scratch_sel && scratch_ok;
  assign wr_bank = i_wdata[`CFG_BANK_MSB:`CFG_BANK_LSB];
  assign wr_bank_valid = !wr_bank[`CFG_BANK_HI_BIT];
  assign wr_idx = wr_bank[1:0];
  assign bank_valid = !bank_ff[`CFG_BANK_HI_BIT];
  assign rd_idx = bank_ff[1:0];

  // =====================================================================
  // bank field, kept as written; restart also clears it
  always_ff @(posedge i_clk) begin
    if (clr_all || i_restart) begin
      bank_ff <= `BANK_RESET;
    end else if (wr_modulator) begin
      bank_ff <= wr_bank;
    end
  end

  // =====================================================================
  // one-hot write hit per generator; a 1xx bank hits none
  always_comb begin
    wr_hit = '0;
    for (int g = 0; g < `NUM_GEN; g++) begin
      if (wr_modulator && wr_bank_valid && (wr_idx == 2'(g))) begin
        wr_hit[g] = 1'b1;
      end
    end
  end

  // =====================================================================
  // per-generator settings
  always_ff @(posedge i_clk) begin
    for (int g = 0; g < `NUM_GEN; g++) begin
      if (clr_all) begin
        freq_ff[g] <= `FREQ_RESET;
      end else if (wr_hit[g]) begin
        freq_ff[g] <= i_wdata[`CFG_FREQ_BIT];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int g = 0; g < `NUM_GEN; g++) begin
      if (clr_all) begin
        duty_ff[g] <= `DUTY_OFF;
      end else if (wr_hit[g]) begin
        duty_ff[g] <= i_wdata[`CFG_DUTY_MSB:`CFG_DUTY_LSB];
      end
    end
  end

  // =====================================================================
  // scratch store: only reset and host writes touch it
  // no restart or mode term: the value outlives fail-safe and restart
  always_ff @(posedge i_clk) begin
    if (clr_all) begin
      scratch_ff <= `SCRATCH_RESET;
    end else if (wr_scratch) begin
      scratch_ff <= i_wdata;
    end
  end

  // =====================================================================
  // configuration readback; reserved bits stay zero
  always_comb begin
    cfg_word = `CFG_RESET;
    cfg_word[`CFG_BANK_MSB:`CFG_BANK_LSB] = bank_ff;
    if (bank_valid) begin
      cfg_word[`CFG_FREQ_BIT] = freq_ff[rd_idx];
      cfg_word[`CFG_DUTY_MSB:`CFG_DUTY_LSB] = duty_ff[rd_idx];
    end
    cfg_word[`CFG_RSVD_HI_BIT] = 1'b0;
    cfg_word[`CFG_RSVD_LO_BIT] = 1'b0;
  end

  // =====================================================================
  // read path
  always_comb begin
    nxt_rdata = '0;
    case (i_reg_sel)
      SEL_MODULATOR: begin
        nxt_rdata = cfg_word;
      end
      SEL_SCRATCH: begin
        if (scratch_ok) begin
          nxt_rdata = scratch_ff;
        end
      end
      default: begin
        nxt_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_ff <= '0;
    end else if (i_rd_en) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= i_rd_en;
    end
  end

  // =====================================================================
  // refused scratch access outside normal mode
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      blocked_ff <= 1'b0;
    end else begin
      blocked_ff <= (i_rd_en || i_wr_en) && scratch_sel && !scratch_ok;
    end
  end

  // =====================================================================
  // generators
  // soft reset restarts every generator at slot zero
  assign gen_bus.clr = clr_all;

  for (genvar g = 0; g < `NUM_GEN; g++) begin : g_gen
    assign gen_bus.freq[g] = freq_ff[g];
    assign gen_bus.duty[g] = duty_ff[g];

    pwm_channel #(
      .IDX(g),
      .SLOT_SLOW(SLOT_SLOW),
      .SLOT_FAST(SLOT_FAST)
    ) u_chan (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .cfg(gen_bus)
    );

    assign mod_out[g] = gen_bus.pwm_out[g];
  end

  // =====================================================================
  // outputs
  assign o_internal_modulator_n = mod_out;
  assign o_rdata = rdata_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_access_blocked = blocked_ff;
endmodule : hs_pwm_gen_config

`default_nettype wire

// ---- src/hs_pwm_defs.svh ----
`ifndef HS_PWM_DEFS_SVH
`define HS_PWM_DEFS_SVH

// =====================================================================
// timing
`define CLK_PERIOD_NS 4
`define PWM_PERIOD_SLOW_NS 10000000
`define PWM_PERIOD_FAST_NS 5000000
`define DUTY_STEPS 1024
// cycles per duty step, rounded down (period is nominal)
`define SLOT_CYC_SLOW ((`PWM_PERIOD_SLOW_NS / `CLK_PERIOD_NS) / `DUTY_STEPS)
`define SLOT_CYC_FAST ((`PWM_PERIOD_FAST_NS / `CLK_PERIOD_NS) / `DUTY_STEPS)
`define SLOT_CNT_W 16

// =====================================================================
// generator configuration layout
`define NUM_GEN 4
`define CFG_RSVD_HI_BIT 15
`define CFG_FREQ_BIT 14
`define CFG_DUTY_MSB 13
`define CFG_DUTY_LSB 4
`define CFG_RSVD_LO_BIT 3
`define CFG_BANK_MSB 2
`define CFG_BANK_LSB 0
`define CFG_BANK_HI_BIT 2
`define CFG_RESET 16'h0000
`define BANK_RESET 3'h0
`define FREQ_RESET 1'h0
`define DUTY_OFF 10'h000
`define DUTY_FULL 10'h3FF

// =====================================================================
// scratch store
`define SCRATCH_RESET 16'h0000
`define REG_W 16

`endif

// ---- src/hs_pwm_pkg.sv ----
`default_nettype none
`include "hs_pwm_defs.svh"

package hs_pwm_pkg;
  typedef logic [9:0] duty_t;
  typedef logic [2:0] bank_t;
  typedef logic [`REG_W-1:0] word_t;
  typedef enum logic {
    SEL_MODULATOR = 1'b0,
    SEL_SCRATCH = 1'b1
  } reg_sel_t;
endpackage : hs_pwm_pkg

`default_nettype wire

// ---- src/gen_cfg_if.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hs_pwm_defs.svh"

interface gen_cfg_if;
  import hs_pwm_pkg::*;
  logic clr;
  logic freq [`NUM_GEN];
  duty_t duty [`NUM_GEN];
  logic pwm_out [`NUM_GEN];
  modport cfg (output clr, output freq, output duty, input pwm_out);
  modport gen (input clr, input freq, input duty, output pwm_out);
endinterface : gen_cfg_if

`default_nettype wire

// ---- src/pwm_channel.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hs_pwm_defs.svh"

module pwm_channel #(
  parameter int IDX = 0,
  parameter int SLOT_SLOW = `SLOT_CYC_SLOW,
  parameter int SLOT_FAST = `SLOT_CYC_FAST
) (
  input wire logic i_clk,
  input wire logic i_srst,
  gen_cfg_if.gen cfg
);
  import hs_pwm_pkg::*;

  localparam logic [`SLOT_CNT_W-1:0] LIM_SLOW = `SLOT_CNT_W'(SLOT_SLOW - 1);
  localparam logic [`SLOT_CNT_W-1:0] LIM_FAST = `SLOT_CNT_W'(SLOT_FAST - 1);

  logic [`SLOT_CNT_W-1:0] pre_ff;
  logic [9:0] slot_ff;
  duty_t duty_ff;
  logic freq_ff;
  logic out_ff;
  logic slot_end;
  logic period_end;

  // =====================================================================
  // timebase from the internal clock
  assign slot_end = (pre_ff == (freq_ff ? LIM_FAST : LIM_SLOW));
  assign period_end = slot_end && (slot_ff == `DUTY_FULL);

  always_ff @(posedge i_clk) begin
    if (i_srst || cfg.clr || slot_end) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + `SLOT_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || cfg.clr) begin
      slot_ff <= '0;
    end else if (slot_end) begin
      slot_ff <= slot_ff + 10'h001; // 1024 steps per period
    end
  end

  // =====================================================================
  // settings take effect at period start, so no runt pulses
  always_ff @(posedge i_clk) begin
    if (i_srst || cfg.clr) begin
      duty_ff <= `DUTY_OFF;
      freq_ff <= `FREQ_RESET;
    end else if (period_end) begin
      duty_ff <= cfg.duty[IDX];
      freq_ff <= cfg.freq[IDX];
    end
  end

  // =====================================================================
  // output
  always_ff @(posedge i_clk) begin
    if (i_srst || cfg.clr) begin
      out_ff <= 1'b0;
    end else if (duty_ff == `DUTY_OFF) begin
      out_ff <= 1'b0;
    end else if (duty_ff == `DUTY_FULL) begin
      out_ff <= 1'b1;
    end else begin
      out_ff <= (slot_ff < duty_ff);
    end
  end

  assign cfg.pwm_out[IDX] = out_ff;
endmodule : pwm_channel

`default_nettype wire

// ---- test/host_mcu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ======
// host side of the register port
module host_mcu_model (
  input wire logic i_clk,
  output logic o_wr_en = 1'b0,
  output logic o_rd_en = 1'b0,
  output hs_pwm_pkg::reg_sel_t o_reg_sel = hs_pwm_pkg::SEL_MODULATOR,
  output hs_pwm_pkg::word_t o_wdata = 16'h0000
);
  import hs_pwm_pkg::*;
  // one strobe cycle, data scrambled once released
  task automatic access(input logic w, input logic r, input reg_sel_t s, input word_t d);
    @(posedge i_clk);
    o_wr_en <= w;
    o_rd_en <= r;
    o_reg_sel <= s;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_rd_en <= 1'b0;
    o_wdata <= ~d;
  endtask : access
endmodule : host_mcu_model
`default_nettype wire

// ---- test/hs_pwm_gen_config_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
// ======
// port checker
module hs_pwm_gen_config_monitor (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_soft_rst,
  input wire logic i_normal_mode,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire hs_pwm_pkg::reg_sel_t i_reg_sel,
  input wire hs_pwm_pkg::word_t i_wdata,
  input wire hs_pwm_pkg::word_t o_rdata,
  input wire logic o_rd_valid,
  input wire logic o_access_blocked,
  input wire logic [3:0] o_internal_modulator_n
);
  import hs_pwm_pkg::*;
  logic blk;
  logic ok;
  assign blk = i_reg_sel == SEL_SCRATCH && !i_normal_mode;
  assign ok = i_reg_sel == SEL_SCRATCH && i_normal_mode && !i_soft_rst;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  chk_rd_answer: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  chk_blk_flag: assert property ((i_rd_en || i_wr_en) && blk |=> o_access_blocked)
    else $error("blocked access not flagged");
  chk_blk_cause: assert property (o_access_blocked |-> $past(blk && (i_rd_en || i_wr_en)))
    else $error("stray blocked flag");
  chk_blk_zero: assert property (i_rd_en && blk |=> o_rdata == 16'h0000)
    else $error("blocked read not zero");
  chk_cfg_rsvd: assert property (i_rd_en && i_reg_sel == SEL_MODULATOR |=> !o_rdata[15] && !o_rdata[3])
    else $error("reserved bit set");
  chk_scr_keep: assert property (
    i_wr_en && !i_rd_en && ok ##1 !i_wr_en && !i_soft_rst ##1 i_rd_en && !i_wr_en && ok
    |=> o_rdata == $past(i_wdata, 3))
    else $error("scratch value lost");
  chk_soft_scr: assert property ($fell(i_soft_rst) && !i_wr_en ##1 i_rd_en && !blk |=> o_rdata == 16'h0000)
    else $error("soft reset left data");
  chk_soft_out: assert property (i_soft_rst [*2] |=> o_internal_modulator_n == 4'h0)
    else $error("soft reset left output");
endmodule : hs_pwm_gen_config_monitor
bind hs_pwm_gen_config hs_pwm_gen_config_monitor i_mon (.i_clk, .i_srst, .i_soft_rst, .i_normal_mode, .i_wr_en,
  .i_rd_en, .i_reg_sel, .i_wdata, .o_rdata, .o_rd_valid, .o_access_blocked, .o_internal_modulator_n);
`default_nettype wire

// ---- test/hs_pwm_gen_config_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module hs_pwm_gen_config_tb;
  import hs_pwm_pkg::*;
  logic i_clk, i_srst, i_soft_rst, i_restart, i_normal_mode, i_wr_en, i_rd_en, o_rd_valid, o_access_blocked;
  reg_sel_t i_reg_sel;
  word_t i_wdata, o_rdata, scr;
  logic [3:0] o_internal_modulator_n, prev;
  logic [16:0] exp_q[$];
  int error_cnt, checked, seed, hi[4], rises[4];
  duty_t duty[4];
  logic freq[4];
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  hs_pwm_gen_config #(.SLOT_SLOW(2), .SLOT_FAST(1)) i_dut (.i_clk, .i_srst, .i_soft_rst, .i_restart, .i_normal_mode,
    .i_wr_en, .i_rd_en, .i_reg_sel, .i_wdata, .o_rdata, .o_rd_valid, .o_access_blocked, .o_internal_modulator_n);
  host_mcu_model i_host (.i_clk, .o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_reg_sel(i_reg_sel), .o_wdata(i_wdata));
  // ======
  // checking and closing
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic rd(input reg_sel_t s, input logic [16:0] e);
    exp_q.push_back(e);
    i_host.access(1'b0, 1'b1, s, 16'h0000);
  endtask : rd
  always @(posedge i_clk) begin
    if (o_rd_valid === 1'b1) begin
      check({o_access_blocked, o_rdata}, exp_q.pop_front());
    end
  end
  // high time and rising edges over one slow period, two fast ones
  task automatic measure();
    hi = '{default: 0};
    rises = '{default: 0};
    prev = o_internal_modulator_n;
    repeat (2048) begin
      @(posedge i_clk);
      for (int g = 0; g < 4; g++) begin
        hi[g] += int'(o_internal_modulator_n[g] === 1'b1);
        rises[g] += int'(o_internal_modulator_n[g] === 1'b1 && prev[g] === 1'b0);
      end
      prev = o_internal_modulator_n;
    end
    for (int g = 0; g < 4; g++) begin
      check(17'(hi[g]), duty[g] == 10'h3FF ? 17'h00800 : 17'(2 * duty[g]));
      check(17'(rises[g]), duty[g] == 10'h000 || duty[g] == 10'h3FF ? 17'h00000 : 17'(freq[g] + 1));
    end
  endtask : measure
  // ======
  // main sequence
  initial begin
    seed = 32'h3426;
    error_cnt = 0;
    checked = 0;
    i_srst = 1'b1;
    i_soft_rst = 1'b0;
    i_restart = 1'b0;
    i_normal_mode = 1'b1;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    duty = '{10'h000, 10'h3FF, 10'h000, 10'h000};
    for (int g = 0; g < 4; g++) begin
      freq[g] = g[0];
      if (g > 1) begin
        duty[g] = 10'h001 + 10'($unsigned($random(seed)) % 1022);
      end
      i_host.access(1'b1, 1'b0, SEL_MODULATOR, {1'b1, freq[g], duty[g], 1'b1, 3'(g)});
      rd(SEL_MODULATOR, {2'h0, freq[g], duty[g], 1'h0, 3'(g)});
    end
    i_host.access(1'b1, 1'b0, SEL_MODULATOR, 16'hFFFD);
    rd(SEL_MODULATOR, 17'h00005);
    repeat (4096) @(posedge i_clk);
    measure();
    scr = word_t'($random(seed));
    i_host.access(1'b1, 1'b0, SEL_SCRATCH, scr);
    rd(SEL_SCRATCH, {1'b0, scr});
    i_restart <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_restart <= 1'b0;
    i_normal_mode <= 1'b0;
    i_host.access(1'b1, 1'b0, SEL_SCRATCH, ~scr);
    rd(SEL_SCRATCH, 17'h10000);
    i_normal_mode <= 1'b1;
    rd(SEL_SCRATCH, {1'b0, scr});
    i_soft_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_soft_rst <= 1'b0;
    rd(SEL_SCRATCH, 17'h00000);
    rd(SEL_MODULATOR, 17'h00000);
    duty = '{default: 10'h000};
    measure();
    check(17'(exp_q.size()), 17'h00000);
    report_and_stop();
  end
endmodule : hs_pwm_gen_config_tb
`default_nettype wire
